// ==== logic/uil_pkg.sv ====
// Shared constants and carriers for the UART interrupt enable and
// identification logic.
// Assumes one system clock; users import uil_pkg::*.
package uil_pkg;

	// ==========================================================
	// Register offsets (byte addresses on the register port)
	localparam int               UIL_ADDR_W     = 8;      // Address width
	localparam int               UIL_DATA_W     = 8;      // Data width
	localparam logic [7:0]       UIL_OFS_RXTX   = 8'h00;  // Rx buffer / Tx hold
	localparam logic [7:0]       UIL_OFS_ENABLE = 8'h04;  // Source enables
	localparam logic [7:0]       UIL_OFS_IDENT  = 8'h08;  // Ident / FIFO ctrl
	localparam logic [7:0]       UIL_OFS_LSTAT  = 8'h14;  // Line status
	localparam logic [7:0]       UIL_OFS_MSTAT  = 8'h18;  // Modem status

	// ==========================================================
	// Enable register fields
	localparam int               UIL_EN_RDA     = 0;      // Rx data + timeout
	localparam int               UIL_EN_THRE    = 1;      // Tx holding empty
	localparam int               UIL_EN_RLS     = 2;      // Rx line status
	localparam int               UIL_EN_MSI     = 3;      // Modem status
	localparam int               UIL_NSRC       = 4;      // Source count
	localparam logic [3:0]       UIL_ENABLE_RST = 4'h0;   // Enable reset value

	// ==========================================================
	// FIFO control fields (write side of the ident offset)
	localparam int               UIL_FC_FIFO_EN = 0;      // FIFO enable bit
	localparam int               UIL_FC_TRIG_LO = 6;      // Trigger field low
	localparam int               UIL_CNT_W      = 5;      // Rx FIFO count width
	localparam logic [4:0]       UIL_TRIG_0     = 5'h01;  // Trigger code 0
	localparam logic [4:0]       UIL_TRIG_1     = 5'h04;  // Trigger code 1
	localparam logic [4:0]       UIL_TRIG_2     = 5'h08;  // Trigger code 2
	localparam logic [4:0]       UIL_TRIG_3     = 5'h0E;  // Trigger code 3
	localparam logic [2:0]       UIL_TO_CHARS   = 3'h4;   // Timeout, chars

	// ==========================================================
	// Identification register fields
	localparam int               UIL_ID_TXFULL  = 4;      // Tx FIFO full bit
	localparam int               UIL_ID_FIFO_LO = 6;      // FIFO mode bits

	// Low nibble identification codes
	typedef enum logic [3:0]
	{
		UIL_IID_NONE = 4'h1,   // Nothing pending
		UIL_IID_RLS  = 4'h6,   // Line error at Rx top
		UIL_IID_RDA  = 4'h4,   // Rx data at trigger
		UIL_IID_CTO  = 4'hC,   // Character timeout
		UIL_IID_THRE = 4'h2,   // Tx holding empty
		UIL_IID_MSI  = 4'h0    // Modem status change
	} uil_iid_e;

	// Receive side status from the Rx path
	typedef struct packed
	{
		logic [UIL_CNT_W-1:0] count;        // Rx FIFO fill level
		logic [3:0]           err;          // Break/frame/parity/overrun
		logic                 holding_full; // Non-FIFO char waiting
		logic                 char_strobe;  // New char just arrived
	} uil_rx_s;

	// Transmit side status from the Tx path
	typedef struct packed
	{
		logic empty;   // Holding reg / FIFO empty
		logic full;    // Tx FIFO full
	} uil_tx_s;

endpackage : uil_pkg

// ==== logic/uil_id_encoder.sv ====
// Five-level priority encoder forming the identification byte.
// Assumes raw source levels already qualified by the caller.
`timescale 1ns/1ps
module uil_id_encoder
	import uil_pkg::*;
(
	input  wire logic [3:0] src_i,     // Raw pending per source
	input  wire logic [3:0] enable_i,  // Source enables
	input  wire logic       timeout_i, // Timeout, part of Rx group
	input  wire logic       fifo_en_i, // FIFO mode
	input  wire logic       tx_full_i, // Tx FIFO full
	output logic      [7:0] ident_o    // Identification byte
);
	// ==========================================================
	// Gating
	logic [3:0] gated;      // Enabled sources
	logic       to_gated;   // Enabled timeout
	uil_iid_e   code;       // Chosen low nibble

	// One gate per source
	genvar gi;
	for (gi = 0; gi < UIL_NSRC; gi++)
	begin : g_gate
		assign gated[gi] = src_i[gi] & enable_i[gi];
	end

	// Timeout only counts in FIFO mode; shares the Rx data enable
	assign to_gated = timeout_i & fifo_en_i & enable_i[UIL_EN_RDA];

	// ==========================================================
	// Priority choice, highest first
	always_comb
	begin
		if (gated[UIL_EN_RLS])
			code = UIL_IID_RLS;
		else if (gated[UIL_EN_RDA])
			code = UIL_IID_RDA;       // Level wins over timeout
		else if (to_gated)
			code = UIL_IID_CTO;
		else if (gated[UIL_EN_THRE])
			code = UIL_IID_THRE;
		else if (gated[UIL_EN_MSI])
			code = UIL_IID_MSI;
		else
			code = UIL_IID_NONE;
	end

	// Upper bits: FIFO mode pair, zero bit, Tx full
	assign ident_o = {{2{fifo_en_i}}, 1'b0, tx_full_i, code};

endmodule : uil_id_encoder

// ==== logic/uil_irq_core.sv ====
// Interrupt enable and identification logic of a UART.
// Assumes Rx/Tx paths and modem status live outside and clear
// their own flags on the read/write pulses this block emits.
//
// Overview of operation
// - Enable bit 3 gates modem status.
// - Enable bit 2 gates line status.
// - Enable bit 1 gates transmit empty.
// - Enable bit 0 gates data and timeout.
// - Report only highest priority pending source.
// - Ident bits 7:6 mirror FIFO enable.
// - Ident bit 5 reads zero.
// - Ident bit 4 shows Tx FIFO full.
// - Ident bit 3 flags timeout, FIFO only.
// - Only enabled sources count as pending.
// - Bit 0 low when pending; else 0001.
// - Line error at Rx top gives 0110.
// - Line interrupt ignores FIFO error summary.
// - Line status read clears line interrupt.
// - Non-FIFO held character gives code 0100.
// - FIFO data interrupt while count >= trigger.
// - Rx buffer read pops and re-evaluates.
// - Data interrupt independent of data-ready flag.
// - Four idle character times give code 1100.
// - Tx write or ident read clears 0010.
// - Modem status bits raise 0000; read clears.
`timescale 1ns/1ps
module uil_irq_core
	import uil_pkg::*;
(
	input  wire logic                       sys_clk_i,         // Clock
	input  wire logic                       reset_i,           // Async rst
	input  wire logic [UIL_ADDR_W-1:0]      reg_addr_i,        // Address
	input  wire logic [UIL_DATA_W-1:0]      reg_wdata_i,       // Wr data
	input  wire logic                       reg_wr_i,          // Wr strobe
	input  wire logic                       reg_rd_i,          // Rd strobe
	output logic      [UIL_DATA_W-1:0]      reg_rdata_o,       // Rd data
	input  wire uil_pkg::uil_rx_s           rx_i,              // Rx status
	input  wire uil_pkg::uil_tx_s           tx_i,              // Tx status
	input  wire logic [3:0]                 modem_delta_i,     // Modem bits
	input  wire logic                       char_time_tick_i,  // Per char
	output logic                            fifo_enable_o,     // FIFO mode
	output logic                            rx_pop_o,          // Rx read
	output logic                            line_status_rd_o,  // LS read
	output logic                            modem_status_rd_o, // MS read
	output logic                            thr_write_o,       // Tx write
	output logic                            irq_o              // Interrupt
);
	// ==========================================================
	// Declarations
	logic [3:0]           enable_q;     // Source enables
	logic                 fifo_en_q;    // FIFO mode bit
	logic [1:0]           trig_sel_q;   // Rx trigger select
	logic [UIL_CNT_W-1:0] trig_lvl;     // Decoded trigger level
	logic                 ls_pend_q;    // Latched line error
	logic [3:0]           err_prev_q;   // Last seen top errors
	logic                 pop_prev_q;   // Pop in last cycle
	logic                 ls_set;       // New error at Rx top
	logic                 thre_pend_q;  // Latched Tx empty
	logic                 empty_prev_q; // Tx empty last cycle
	logic                 thre_set;     // Tx empty event
	logic                 thre_clr;     // Tx empty clear
	logic [2:0]           to_cnt_q;     // Idle char counter
	logic                 to_pend;      // Timeout reached
	logic                 rda_src;      // Rx data source level
	logic [3:0]           src;          // Raw source levels
	logic [7:0]           ident;        // Live ident byte
	logic [UIL_DATA_W-1:0] rdata_q;     // Read data register
	logic                 irq_q;        // Registered interrupt

	// Decoded access pulses
	logic wr_enable;   // Write to enables
	logic wr_fctl;     // Write to FIFO control
	logic rd_ident;    // Read of ident

	assign wr_enable = reg_wr_i & (reg_addr_i == UIL_OFS_ENABLE);
	assign wr_fctl   = reg_wr_i & (reg_addr_i == UIL_OFS_IDENT);
	assign rd_ident  = reg_rd_i & (reg_addr_i == UIL_OFS_IDENT);

	// Side-effect pulses for neighbouring registers
	assign rx_pop_o          = reg_rd_i & (reg_addr_i == UIL_OFS_RXTX);
	assign thr_write_o       = reg_wr_i & (reg_addr_i == UIL_OFS_RXTX);
	assign line_status_rd_o  = reg_rd_i & (reg_addr_i == UIL_OFS_LSTAT);
	assign modem_status_rd_o = reg_rd_i & (reg_addr_i == UIL_OFS_MSTAT);

	// ==========================================================
	// Enable register
	always_ff @(posedge sys_clk_i or posedge reset_i)
	begin
		if (reset_i)
			enable_q <= UIL_ENABLE_RST;
		else if (wr_enable)
			enable_q <= reg_wdata_i[3:0];
	end

	// ==========================================================
	// FIFO control copy: mode bit and trigger select
	always_ff @(posedge sys_clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			fifo_en_q  <= 1'b0;
			trig_sel_q <= 2'h0;
		end
		else if (wr_fctl)
		begin
			fifo_en_q  <= reg_wdata_i[UIL_FC_FIFO_EN];
			trig_sel_q <= reg_wdata_i[UIL_FC_TRIG_LO +: 2];
		end
	end

	assign fifo_enable_o = fifo_en_q;

	// Trigger level lookup
	always_comb
	begin
		case (trig_sel_q)
			2'h0:    trig_lvl = UIL_TRIG_0;
			2'h1:    trig_lvl = UIL_TRIG_1;
			2'h2:    trig_lvl = UIL_TRIG_2;
			default: trig_lvl = UIL_TRIG_3;
		endcase
	end

	// ==========================================================
	// Line status source
	// Only the top entry's error bits feed this; the FIFO-wide
	// error summary never enters, so a stale error deeper in the
	// FIFO cannot raise it early.
	assign ls_set = (rx_i.err != 4'h0) &
	                ((rx_i.err != err_prev_q) | pop_prev_q);

	// Track top-entry changes
	always_ff @(posedge sys_clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			err_prev_q <= 4'h0;
			pop_prev_q <= 1'b0;
		end
		else
		begin
			err_prev_q <= rx_i.err;
			pop_prev_q <= rx_pop_o;
		end
	end

	// Sticky flag; a new error beats a same-cycle read
	always_ff @(posedge sys_clk_i or posedge reset_i)
	begin
		if (reset_i)
			ls_pend_q <= 1'b0;
		else if (ls_set)
			ls_pend_q <= 1'b1;
		else if (line_status_rd_o)
			ls_pend_q <= 1'b0;
	end

	// ==========================================================
	// Received data source
	// Uses fill level or holding flag, never the data-ready bit.
	assign rda_src = fifo_en_q ? (rx_i.count >= trig_lvl)
	                           : rx_i.holding_full;

	// ==========================================================
	// Character timeout counter
	// Restarts on any arrival or Rx buffer read, saturates at
	// the limit so the source holds until the next arrival or pop.
	always_ff @(posedge sys_clk_i or posedge reset_i)
	begin
		if (reset_i)
			to_cnt_q <= 3'h0;
		else if (!fifo_en_q || rx_i.char_strobe || rx_pop_o ||
		         rx_i.count == '0)
			to_cnt_q <= 3'h0;
		else if (char_time_tick_i && to_cnt_q != UIL_TO_CHARS)
			to_cnt_q <= to_cnt_q + 3'h1;
	end

	assign to_pend = (to_cnt_q == UIL_TO_CHARS);

	// ==========================================================
	// Transmit holding empty source
	assign thre_set = (tx_i.empty & ~empty_prev_q) |
	                  (wr_enable & reg_wdata_i[UIL_EN_THRE] &
	                   ~enable_q[UIL_EN_THRE] & tx_i.empty);
	// Ident read clears only when it is the shown code
	assign thre_clr = thr_write_o |
	                  (rd_ident & ident[3:0] == UIL_IID_THRE);

	// Remember last empty level
	always_ff @(posedge sys_clk_i or posedge reset_i)
	begin
		if (reset_i)
			empty_prev_q <= 1'b0;
		else
			empty_prev_q <= tx_i.empty;
	end

	// Sticky flag; set beats clear
	always_ff @(posedge sys_clk_i or posedge reset_i)
	begin
		if (reset_i)
			thre_pend_q <= 1'b0;
		else if (thre_set)
			thre_pend_q <= 1'b1;
		else if (thre_clr)
			thre_pend_q <= 1'b0;
	end

	// ==========================================================
	// Source vector and encoder
	assign src[UIL_EN_RDA]  = rda_src;
	assign src[UIL_EN_THRE] = thre_pend_q;
	assign src[UIL_EN_RLS]  = ls_pend_q;
	assign src[UIL_EN_MSI]  = |modem_delta_i;

	// Gating and priority in one place.
	uil_id_encoder u_enc
	(
		.src_i     (src),
		.enable_i  (enable_q),
		.timeout_i (to_pend),
		.fifo_en_i (fifo_en_q),
		.tx_full_i (tx_i.full),
		.ident_o   (ident)
	);

	// ==========================================================
	// Read data, one cycle after the strobe
	// Neighbouring registers read as zero here; the system
	// muxes their own data in.
	always_ff @(posedge sys_clk_i or posedge reset_i)
	begin
		if (reset_i)
			rdata_q <= 8'h00;
		else if (reg_rd_i)
		begin
			case (reg_addr_i)
				UIL_OFS_ENABLE: rdata_q <= {4'h0, enable_q};
				UIL_OFS_IDENT:  rdata_q <= ident;
				default:        rdata_q <= 8'h00;
			endcase
		end
	end

	assign reg_rdata_o = rdata_q;

	// ==========================================================
	// Interrupt output, registered to avoid glitches
	always_ff @(posedge sys_clk_i or posedge reset_i)
	begin
		if (reset_i)
			irq_q <= 1'b0;
		else
			irq_q <= ~ident[0];
	end

	assign irq_o = irq_q;

	// ==========================================================
	// Checks
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (reset_i);

	property p_msi_gate;
		!enable_q[UIL_EN_MSI] |-> ident[3:0] != UIL_IID_MSI;
	endproperty
	a_msi_gate: assert property (p_msi_gate)
		else $error("modem source reported while disabled");

	property p_rls_gate;
		!enable_q[UIL_EN_RLS] |-> ident[3:0] != UIL_IID_RLS;
	endproperty
	a_rls_gate: assert property (p_rls_gate)
		else $error("line source reported while disabled");

	property p_thre_gate;
		!enable_q[UIL_EN_THRE] |-> ident[3:0] != UIL_IID_THRE;
	endproperty
	a_thre_gate: assert property (p_thre_gate)
		else $error("tx empty reported while disabled");

	property p_rda_gate;
		!enable_q[UIL_EN_RDA] |-> ident[2:0] != 3'h4;
	endproperty
	a_rda_gate: assert property (p_rda_gate)
		else $error("rx data or timeout reported while disabled");

	property p_rls_prio;
		ls_pend_q && enable_q[UIL_EN_RLS] |-> ident[3:0] == UIL_IID_RLS;
	endproperty
	a_rls_prio: assert property (p_rls_prio)
		else $error("line status not top priority");

	property p_upper;
		ident[7:4] == {{2{fifo_en_q}}, 1'b0, tx_i.full};
	endproperty
	a_upper: assert property (p_upper)
		else $error("ident upper bits wrong");

	property p_bit3;
		!fifo_en_q |-> !ident[3];
	endproperty
	a_bit3: assert property (p_bit3)
		else $error("timeout bit set outside FIFO mode");

	property p_irq;
		!ident[0] |=> irq_o;
	endproperty
	a_irq: assert property (p_irq)
		else $error("interrupt output missed pending");

	// Output must also drop once nothing is pending
	property p_irq_idle;
		ident[0] |=> !irq_o;
	endproperty
	a_irq_idle: assert property (p_irq_idle)
		else $error("interrupt output set with nothing pending");

	// Ident read that shows tx empty retires that source
	property p_thre_id_clr;
		rd_ident && (ident[3:0] == UIL_IID_THRE) && !thre_set
			|=> !thre_pend_q;
	endproperty
	a_thre_id_clr: assert property (p_thre_id_clr)
		else $error("ident read did not clear tx empty source");

	property p_ls_clear;
		line_status_rd_o && !ls_set |=> !ls_pend_q;
	endproperty
	a_ls_clear: assert property (p_ls_clear)
		else $error("line status read did not clear");

	property p_thr_clear;
		thr_write_o && !thre_set |=> !thre_pend_q;
	endproperty
	a_thr_clear: assert property (p_thr_clear)
		else $error("tx write did not clear empty source");

	property p_rd_ident;
		rd_ident |=> reg_rdata_o == $past(ident);
	endproperty
	a_rd_ident: assert property (p_rd_ident)
		else $error("ident read data wrong");

	c_rls:  cover property (ident[3:0] == UIL_IID_RLS);
	c_cto:  cover property (ident[3:0] == UIL_IID_CTO);
	c_thre: cover property (rd_ident && ident[3:0] == UIL_IID_THRE);
	c_msi:  cover property (enable_q[UIL_EN_MSI] && ident[3:0] == UIL_IID_MSI);

endmodule : uil_irq_core

// ==== bench/uil_irq_core_bench.sv ====
// Self-checking bench for the UART interrupt enable and ident logic.
// Assumes uil_pkg and uil_irq_core are compiled first; the bench plays
// the register master and the Rx, Tx and modem paths itself.
`timescale 1ns/1ps
module uil_irq_core_bench;
	import uil_pkg::*;

	// ==========================================================
	// Signals
	logic             sys_clk_i;  // 25 MHz clock
	logic             reset_i;    // Async reset, active high
	logic [7:0]       addr;       // Register address
	logic [7:0]       wdata;      // Write data
	logic             wr;         // Write strobe
	logic             rd;         // Read strobe
	logic [7:0]       rdata;      // Read data
	uil_rx_s          rx;         // Rx path status
	uil_tx_s          tx;         // Tx path status
	logic [3:0]       modem;      // Modem status bits
	logic             tick;       // Character time tick
	logic             fifo_en;    // FIFO mode output
	logic [3:0]       pulse;      // Pop, line rd, modem rd, tx write
	logic             irq;        // Interrupt output
	int               n_errors;   // Mismatches
	int               compares;   // Comparisons made
	int               cycles;     // Watchdog count
	int               seen_p [4]; // Side pulses seen
	int               want_p [4]; // Side pulses expected
	logic [4:0]       trig [4];   // Trigger levels per code

	// ==========================================================
	// Device under test
	uil_irq_core uut
	(
		.sys_clk_i         (sys_clk_i),
		.reset_i           (reset_i),
		.reg_addr_i        (addr),
		.reg_wdata_i       (wdata),
		.reg_wr_i          (wr),
		.reg_rd_i          (rd),
		.reg_rdata_o       (rdata),
		.rx_i              (rx),
		.tx_i              (tx),
		.modem_delta_i     (modem),
		.char_time_tick_i  (tick),
		.fifo_enable_o     (fifo_en),
		.rx_pop_o          (pulse[0]),
		.line_status_rd_o  (pulse[1]),
		.modem_status_rd_o (pulse[2]),
		.thr_write_o       (pulse[3]),
		.irq_o             (irq)
	);

	// ==========================================================
	// Clock
	initial sys_clk_i = 1'b0;
	always #20 sys_clk_i = ~sys_clk_i;

	// Outside paths: count side pulses, clear what they consume
	// A hang stops at the watchdog instead of running forever
	always @(posedge sys_clk_i)
	begin
		cycles <= cycles + 1;
		for (int i = 0; i < 4; i++)
			seen_p[i] <= seen_p[i] + int'(pulse[i]);
		if (pulse[0])
			rx.holding_full <= 1'b0;
		if (pulse[2])
			modem <= 4'h0;
		if (cycles == 3000)
		begin
			n_errors = n_errors + 1;
			wrap_up();
		end
	end

	// ==========================================================
	// Tasks
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	// One-cycle write; a gap follows so the strobe never doubles
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk_i);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge sys_clk_i);
		wr    <= 1'b0;
		if (a == UIL_OFS_RXTX)
			want_p[3]++;
	endtask : wr_reg

	// One-cycle read; data looked at in the following cycle only
	task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
		@(posedge sys_clk_i);
		addr <= a;
		rd   <= 1'b1;
		@(posedge sys_clk_i);
		rd   <= 1'b0;
		#1;
		chk(rdata, exp);
		if (a == UIL_OFS_RXTX)
			want_p[0]++;
		if (a == UIL_OFS_LSTAT)
			want_p[1]++;
		if (a == UIL_OFS_MSTAT)
			want_p[2]++;
	endtask : rd_reg

	// Ident read after flags settle; interrupt line must agree
	task automatic rd_id(input logic [7:0] exp);
		repeat (2) @(posedge sys_clk_i);
		rd_reg(UIL_OFS_IDENT, exp);
		chk({7'h00, irq}, {7'h00, ~exp[0]});
	endtask : rd_id

	task automatic set_cnt(input logic [4:0] c);
		@(posedge sys_clk_i);
		rx.count <= c;
	endtask : set_cnt

	// Character time ticks, each one cycle wide
	task automatic ticks(input int n);
		repeat (n)
		begin
			@(posedge sys_clk_i);
			tick <= 1'b1;
			@(posedge sys_clk_i);
			tick <= 1'b0;
		end
	endtask : ticks

	task automatic wrap_up();
		if (n_errors == 0 && compares > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : wrap_up

	// ==========================================================
	// Main sequence
	initial
	begin
		reset_i = 1'b1;
		{addr, wdata, wr, rd, modem, tick} = '0;
		rx = '0;
		tx = '0;
		{n_errors, compares, cycles} = '0;
		seen_p = '{0, 0, 0, 0};
		want_p = '{0, 0, 0, 0};
		trig = '{UIL_TRIG_0, UIL_TRIG_1, UIL_TRIG_2, UIL_TRIG_3};
		repeat (20) @(posedge sys_clk_i);
		reset_i <= 1'b0;
		rd_id(8'h01);
		wr_reg(UIL_OFS_ENABLE, 8'hF0);
		rd_reg(UIL_OFS_ENABLE, 8'h00);
		// Every source raised while all enables are off
		@(posedge sys_clk_i);
		rx.holding_full <= 1'b1;
		rx.err          <= 4'h2;
		tx.empty        <= 1'b1;
		modem           <= 4'h1;
		rd_id(8'h01);
		wr_reg(UIL_OFS_ENABLE, 8'h08);
		rd_id(8'h00);
		wr_reg(UIL_OFS_ENABLE, 8'h0A);
		rd_id(8'h02);
		rd_id(8'h00);
		wr_reg(UIL_OFS_ENABLE, 8'h0B);
		rd_id(8'h04);
		wr_reg(UIL_OFS_ENABLE, 8'hFF);
		rd_reg(UIL_OFS_ENABLE, 8'h0F);
		// Each error kind at the Rx top, cleared by a status read
		for (int i = 0; i < 4; i++)
		begin
			@(posedge sys_clk_i);
			rx.err <= 4'h1 << i;
			rd_id(8'h06);
			rd_reg(UIL_OFS_LSTAT, 8'h00);
			rd_id(8'h04);
		end
		@(posedge sys_clk_i);
		rx.err   <= 4'h0;
		tx.empty <= 1'b0;   // Tx refills, then drains: fresh empty edge
		@(posedge sys_clk_i);
		tx.empty <= 1'b1;
		rd_reg(UIL_OFS_RXTX, 8'h00);
		rd_id(8'h02);
		// Enable bit 1 going 0 to 1 while empty re-arms tx empty
		wr_reg(UIL_OFS_ENABLE, 8'h0D);
		wr_reg(UIL_OFS_ENABLE, 8'h0F);
		wr_reg(UIL_OFS_RXTX, 8'h5A);
		rd_id(8'h00);
		rd_reg(UIL_OFS_MSTAT, 8'h00);
		rd_id(8'h01);
		// FIFO mode: every trigger code at and just below its level
		for (int k = 0; k < 4; k++)
		begin
			wr_reg(UIL_OFS_IDENT, {k[1:0], 6'h01});
			set_cnt(trig[k] - 5'h01);
			rd_id(8'hC1);
			set_cnt(trig[k]);
			rd_id(8'hC4);
		end
		@(posedge sys_clk_i);
		tx.full <= 1'b1;
		rd_id(8'hD4);
		chk({7'h00, fifo_en}, 8'h01);
		// Timeout: a new character restarts the idle count
		wr_reg(UIL_OFS_IDENT, 8'h41);
		set_cnt(5'h01);
		ticks(3);
		@(posedge sys_clk_i);
		rx.char_strobe <= 1'b1;
		@(posedge sys_clk_i);
		rx.char_strobe <= 1'b0;
		ticks(3);
		rd_id(8'hD1);
		ticks(1);
		rd_id(8'hDC);
		rd_reg(UIL_OFS_RXTX, 8'h00);
		rd_id(8'hD1);
		wr_reg(UIL_OFS_ENABLE, 8'h0C);
		ticks(4);
		rd_id(8'hD1);
		wr_reg(UIL_OFS_IDENT, 8'h00);
		rd_id(8'h11);
		// Unmapped place reads zero and ignores writes
		rd_reg(8'h1C, 8'h00);
		wr_reg(8'h1C, 8'hFF);
		rd_reg(UIL_OFS_ENABLE, 8'h0C);
		repeat (2) @(posedge sys_clk_i);
		for (int i = 0; i < 4; i++)
			chk(seen_p[i][7:0], want_p[i][7:0]);
		wrap_up();
	end

endmodule : uil_irq_core_bench
